// [logic/shr_defines.svh]
`ifndef SHR_DEFINES_SVH
`define SHR_DEFINES_SVH
// ----------------------------------------
// register word offsets (word addresses)
// ----------------------------------------
`define SHR_OFF_CTRL    4'h0
`define SHR_OFF_STATUS  4'h1
`define SHR_OFF_DATA    4'h2
`define SHR_OFF_EVENT   4'h3
`define SHR_OFF_MASK    4'h4
// ----------------------------------------
// control field positions
// ----------------------------------------
`define SHR_CTL_ENABLE  0
`define SHR_CTL_HWACK   1
`define SHR_CTL_START   2
`define SHR_CTL_STOP    3
`define SHR_CTL_ACK     4
`define SHR_CTL_SI      5
// ----------------------------------------
// status vectors
// ----------------------------------------
`define SHR_SV_MRX      4'h8
`define SHR_SV_MTX      4'hc
`define SHR_SV_START    4'he
`define SHR_SV_STX      4'h4
`define SHR_SV_STXERR   4'h5
`define SHR_SV_STOPDET  4'h1
`define SHR_SV_IDLE     4'h0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SHR_CTRL_RST    6'h00
`define SHR_MASK_RST    3'h0
`define SHR_HALF_NS     5000
`define SHR_CLK_NS      20
`define SHR_HALF_CYC    (`SHR_HALF_NS / `SHR_CLK_NS)
`endif

// [logic/shr_pkg.sv]
package shr_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_START = 7'b0000010,
    ST_ADDR  = 7'b0000100,
    ST_RXB   = 7'b0001000,
    ST_TXB   = 7'b0010000,
    ST_HOLD  = 7'b0100000,
    ST_STOP  = 7'b1000000
  } shr_state_e;

  typedef struct packed {
    logic       si;
    logic       ack;
    logic       stop_request;
    logic       start_request;
    logic       hw_ack_enable;
    logic       enable;
  } shr_ctrl_s;

  typedef struct packed {
    logic [3:0] vector;
    logic       ack_request_flag;
    logic       arbitration_lost_flag;
    logic       ack_seen;
  } shr_status_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } shr_pins_s;
endpackage

// [logic/shr_hwack.sv]
`timescale 1ns/1ps
`include "shr_defines.svh"
module shr_hwack #(
  parameter int HALF_CYC = `SHR_HALF_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output shr_pkg::shr_pins_s     pins,
  input  wire logic              slave_sel
);
  import shr_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_prev_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
    end
  end
  wire scl_s   = scl_sync_q[1];
  wire sda_s   = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  logic sda_prev_q;
  always_ff @(posedge mclk) begin
    if (!rst_n)
      sda_prev_q <= 1'b1;
    else if (clk_en)
      sda_prev_q <= sda_s;
  end
  wire stop_seen  = scl_s & sda_s & ~sda_prev_q;
  wire start_seen = scl_s & ~sda_s & sda_prev_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  shr_ctrl_s  ctrl_q;
  shr_status_s stat_q;
  logic [7:0] data_q;
  logic [7:0] shift_q;
  logic [2:0] event_q, mask_q;
  logic       data_wr_q;
  logic       master_q;
  shr_state_e state_q;
  logic [3:0] bit_q;
  logic [15:0] tick_q;
  logic       si_set, tx_done_ev, rx_done_ev, err_ev;

  // single-cycle answer: waitrequest only during the first cycle of a request
  logic ack_q;
  always_ff @(posedge mclk) begin
    if (!rst_n)
      ack_q <= 1'b0;
    else if (clk_en)
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  wire wr_go = avs_write & ack_q & clk_en;
  wire rd_go = avs_read & ack_q & clk_en;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (clk_en && avs_read && !ack_q) begin
      case (avs_address)
        `SHR_OFF_CTRL:   avs_readdata <= {26'h0, ctrl_q};
        `SHR_OFF_STATUS: avs_readdata <= {25'h0, stat_q};
        `SHR_OFF_DATA:   avs_readdata <= {24'h0, data_q};
        `SHR_OFF_EVENT:  avs_readdata <= {29'h0, event_q};
        `SHR_OFF_MASK:   avs_readdata <= {29'h0, mask_q};
        default:         avs_readdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // control register and interrupt flag
  // ----------------------------------------
  wire wr_ctrl = wr_go && avs_address == `SHR_OFF_CTRL;
  // pending data write is consumed when the held bus is let go, not at the write
  wire si_clear = state_q == ST_HOLD && !ctrl_q.si;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= `SHR_CTRL_RST;
    end else if (clk_en) begin
      if (wr_ctrl)
        ctrl_q <= avs_writedata[5:0];
      if (si_set)
        ctrl_q.si <= 1'b1;   // set beats clear
      if (state_q == ST_START && tick_q == 16'h0)
        ctrl_q.start_request <= 1'b0;
      if (state_q == ST_STOP && tick_q == 16'h0)
        ctrl_q.stop_request <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_q    <= 8'h0;
      data_wr_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_go && avs_address == `SHR_OFF_DATA) begin
        data_q    <= avs_writedata[7:0];
        data_wr_q <= 1'b1;
      end else if (si_clear)
        data_wr_q <= 1'b0;
      if (rx_done_ev)
        data_q <= shift_q;
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  wire [2:0] ev_in = {err_ev, rx_done_ev, tx_done_ev};
  wire rd_event = rd_go && avs_address == `SHR_OFF_EVENT;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      event_q <= 3'h0;
      mask_q  <= `SHR_MASK_RST;
    end else if (clk_en) begin
      event_q <= (rd_event ? 3'h0 : event_q) | ev_in;
      if (wr_go && avs_address == `SHR_OFF_MASK)
        mask_q <= avs_writedata[2:0];
    end
  end
  assign irq = |(event_q & mask_q);

  // ----------------------------------------
  // bus engine
  // ----------------------------------------
  logic scl_drv_q, sda_drv_q;
  logic last_nack_q;
  assign si_set     = ((state_q == ST_RXB || state_q == ST_TXB) && scl_fall && bit_q == 4'h9)
                      || (state_q == ST_START && tick_q == 16'h0);
  assign tx_done_ev = state_q == ST_TXB && si_set;
  assign rx_done_ev = state_q == ST_RXB && si_set;
  assign err_ev     = state_q == ST_TXB && !master_q && stop_seen && bit_q != 4'h0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      bit_q       <= 4'h0;
      tick_q      <= 16'h0;
      shift_q     <= 8'h0;
      master_q    <= 1'b0;
      scl_drv_q   <= 1'b0;
      sda_drv_q   <= 1'b0;
      last_nack_q <= 1'b0;
      stat_q      <= '0;
    end else if (clk_en) begin
      if (tick_q != 16'h0)
        tick_q <= tick_q - 16'h1;
      case (state_q)
        ST_IDLE: begin
          scl_drv_q <= 1'b0;
          sda_drv_q <= 1'b0;
          if (ctrl_q.enable && !ctrl_q.si && ctrl_q.start_request) begin
            state_q <= ST_START;
            tick_q  <= 16'(HALF_CYC);
          end else if (slave_sel && ctrl_q.hw_ack_enable) begin
            state_q  <= ST_TXB;
            master_q <= 1'b0;
            shift_q  <= data_q;
            bit_q    <= 4'h0;
          end
        end
        ST_START: begin
          sda_drv_q <= 1'b1;
          if (tick_q == 16'h0) begin
            scl_drv_q     <= 1'b1;
            master_q      <= 1'b1;
            stat_q.vector <= `SHR_SV_START;
            state_q       <= ST_HOLD;
          end
        end
        ST_RXB, ST_TXB: begin
          // as master we make the link clock from the half-period counter
          if (master_q && tick_q == 16'h0) begin
            scl_drv_q <= ~scl_drv_q;
            tick_q    <= 16'(HALF_CYC);
          end
          if (scl_rise && bit_q < 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + 4'h1;
          end else if (scl_rise && bit_q == 4'h8) begin
            stat_q.ack_seen <= ~sda_s;
            bit_q           <= 4'h9;
          end
          if (scl_fall && bit_q < 4'h8)
            sda_drv_q <= (state_q == ST_TXB) && !shift_q[7];
          if (scl_fall && bit_q == 4'h8 && state_q == ST_TXB)
            sda_drv_q <= 1'b0;        // release for the far side's ack
          if (scl_fall && bit_q == 4'h8 && state_q == ST_RXB && ctrl_q.hw_ack_enable)
            sda_drv_q <= ctrl_q.ack;
          if (si_set) begin
            scl_drv_q   <= 1'b1;
            sda_drv_q   <= 1'b0;
            state_q     <= ST_HOLD;
            bit_q       <= 4'h0;
            last_nack_q <= state_q == ST_RXB && !ctrl_q.ack;
            stat_q.ack_request_flag <= 1'b0;
            if (state_q == ST_RXB)
              stat_q.vector <= `SHR_SV_MRX;
            else if (!master_q)
              stat_q.vector <= `SHR_SV_STX;
            else
              stat_q.vector <= `SHR_SV_MTX;
          end
          if (err_ev) begin
            stat_q.vector <= `SHR_SV_STXERR;
            state_q       <= ST_HOLD;
            scl_drv_q     <= 1'b0;
            sda_drv_q     <= 1'b0;
          end
          if (!master_q && !sda_drv_q && sda_s == 1'b0 && scl_rise && bit_q < 4'h8
              && state_q == ST_TXB && shift_q[7])
            stat_q.arbitration_lost_flag <= 1'b1;
        end
        ST_HOLD: begin
          if (!ctrl_q.si) begin
            scl_drv_q <= 1'b0;
            if (stat_q.vector == `SHR_SV_STXERR) begin
              state_q <= ST_IDLE;
            end else if (!master_q && (stat_q.arbitration_lost_flag || !stat_q.ack_seen)) begin
              state_q <= ST_STOP;
              tick_q  <= 16'h0;
            end else if (ctrl_q.stop_request) begin
              state_q <= ST_STOP;
              tick_q  <= 16'(HALF_CYC);
              sda_drv_q <= 1'b1;
            end else if (ctrl_q.start_request) begin
              state_q <= ST_START;
              sda_drv_q <= 1'b0;
              tick_q  <= 16'(HALF_CYC);
            end else if (data_wr_q || stat_q.vector == `SHR_SV_STX) begin
              state_q   <= ST_TXB;
              shift_q   <= data_q;
              sda_drv_q <= !data_q[7];    // first bit set up in the same cycle as clock release
              tick_q    <= 16'(HALF_CYC);
            end else if (!last_nack_q) begin
              state_q <= ST_RXB;
              tick_q  <= 16'(HALF_CYC);
            end
          end
        end
        ST_STOP: begin
          if (master_q) begin
            if (tick_q == 16'h0) begin
              sda_drv_q <= 1'b0;
              master_q  <= 1'b0;
              state_q   <= ctrl_q.start_request ? ST_START : ST_IDLE;
              tick_q    <= 16'(HALF_CYC);
            end
          end else if (stop_seen || start_seen) begin
            stat_q.vector <= `SHR_SV_STOPDET;
            stat_q.arbitration_lost_flag <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign pins.scl_o  = 1'b0;
  assign pins.sda_o  = 1'b0;
  assign pins.scl_oe = scl_drv_q;
  assign pins.sda_oe = sda_drv_q;
endmodule

// [verif/shr_hwack_properties.sv]
`timescale 1ns/1ps
`include "shr_defines.svh"
module shr_hwack_properties #(
  parameter int HALF_CYC = 4
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic [3:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  input wire logic             irq,
  input wire logic             scl_i,
  input wire logic             sda_i,
  input wire shr_pkg::shr_pins_s pins
);
  import shr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic ctl_wr;
  assign req    = avs_read | avs_write;
  assign ctl_wr = avs_write & ~avs_waitrequest & (avs_address == `SHR_OFF_CTRL);
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("waitrequest low on first request cycle");
  a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h4
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_open_drain: assert property (!pins.scl_o && !pins.sda_o)
    else $error("pin driven high");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq && pins == 4'h0)
    else $error("outputs active after reset");
  a_mask_irq: assert property (avs_write && !avs_waitrequest && avs_address == `SHR_OFF_MASK
    && avs_writedata[2:0] == 3'h0 |=> !irq) else $error("irq with all masked");
  a_si_holds_scl: assert property (avs_read && !avs_waitrequest
    && avs_address == `SHR_OFF_CTRL && avs_readdata[`SHR_CTL_SI] |-> pins.scl_oe)
    else $error("clock not held while flag set");
  a_stop_frees: assert property (ctl_wr && avs_writedata[`SHR_CTL_STOP]
    && !avs_writedata[`SHR_CTL_START] |-> ##[1:200] (!pins.scl_oe && !pins.sda_oe))
    else $error("bus not released after stop");
  a_stop_restart: assert property (ctl_wr && avs_writedata[`SHR_CTL_STOP]
    && avs_writedata[`SHR_CTL_START] |-> ##[1:300] ($fell(sda_i) && scl_i))
    else $error("no start after stop");
endmodule
bind shr_hwack shr_hwack_properties #(.HALF_CYC(HALF_CYC)) i_props (
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl_i), .sda_i(sda_i), .pins(pins)
);

// [verif/shr_slave_model.sv]
`timescale 1ns/1ps
module shr_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'ha5
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_pull
);
  int         cnt = 0;
  logic       act = 1'b0;
  logic       addr_ph = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] sh = 8'h00;
  initial sda_pull = 1'b0;
  // start and stop are data edges while the clock is high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      addr_ph = 1'b1;
      cnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b0;
      sda_pull = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (addr_ph) rd = sh[0];
      else if (sda) act = 1'b0;
      if (cnt == 8) addr_ph = 1'b0;
      cnt = (cnt == 8) ? 0 : cnt + 1;
    end
  end
  // released line floats to the pull-up level
  always @(negedge scl) begin
    if (!act) sda_pull = 1'b0;
    else if (addr_ph || !rd) sda_pull = (cnt == 8);
    else sda_pull = (cnt < 8) ? ~RD_BYTE[3'(7 - cnt)] : 1'b0;
  end
endmodule

// [verif/shr_hwack_bench.sv]
`timescale 1ns/1ps
`include "shr_defines.svh"
module shr_hwack_bench;
  import shr_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        slave_sel;
  logic        slv_pull;
  logic        scl_w;
  logic        sda_w;
  shr_pins_s   pins;
  logic [31:0] rd;
  int          fail_count;
  int          n_tests;
  assign scl_w = ~pins.scl_oe;
  assign sda_w = ~(pins.sda_oe | slv_pull);
  shr_hwack #(.HALF_CYC(4)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .scl_i(scl_w), .sda_i(sda_w), .pins(pins), .slave_sel(slave_sel)
  );
  shr_slave_model i_slave (.scl(scl_w), .sda(sda_w), .sda_pull(slv_pull));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= ~we;
    avs_write     <= we;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_si;
    int n;
    n = 0;
    do begin
      bus(1'b0, `SHR_OFF_CTRL, 32'h0);
      n++;
    end while (rd[`SHR_CTL_SI] !== 1'b1 && n < 400);
    if (n >= 400) fail_count++;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    slave_sel = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, `SHR_OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'(`SHR_CTRL_RST));
    bus(1'b0, `SHR_OFF_MASK, 32'h0);
    check("mask reset", rd, 32'(`SHR_MASK_RST));
    bus(1'b1, 4'h7, 32'hff);
    bus(1'b0, 4'h7, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, `SHR_OFF_MASK, 32'h7);
    bus(1'b1, `SHR_OFF_CTRL, 32'h07);
    wait_si();
    bus(1'b0, `SHR_OFF_STATUS, 32'h0);
    check("start vector", rd[6:3], 32'(`SHR_SV_START));
    bus(1'b1, `SHR_OFF_DATA, 32'h55);
    bus(1'b1, `SHR_OFF_CTRL, 32'h13);
    wait_si();
    bus(1'b0, `SHR_OFF_STATUS, 32'h0);
    check("address vector", rd[6:3], 32'(`SHR_SV_MTX));
    bus(1'b1, `SHR_OFF_CTRL, 32'h13);
    wait_si();
    bus(1'b0, `SHR_OFF_STATUS, 32'h0);
    check("acked byte", {rd[6:3], rd[0]}, {`SHR_SV_MRX, 1'b1});
    check("irq raised", irq, 32'h1);
    bus(1'b0, `SHR_OFF_DATA, 32'h0);
    check("data one", rd[7:0], 32'ha5);
    bus(1'b0, `SHR_OFF_EVENT, 32'h0);
    check("rx event", rd[1], 32'h1);
    repeat (2) @(negedge mclk);
    check("irq cleared", irq, 32'h0);
    bus(1'b1, `SHR_OFF_CTRL, 32'h03);
    wait_si();
    bus(1'b0, `SHR_OFF_STATUS, 32'h0);
    check("nacked byte", {rd[6:3], rd[0]}, {`SHR_SV_MRX, 1'b0});
    bus(1'b0, `SHR_OFF_DATA, 32'h0);
    check("data two", rd[7:0], 32'ha5);
    bus(1'b1, `SHR_OFF_CTRL, 32'h0f);
    wait_si();
    bus(1'b0, `SHR_OFF_STATUS, 32'h0);
    check("restart vector", rd[6:3], 32'(`SHR_SV_START));
    bus(1'b1, `SHR_OFF_CTRL, 32'h0b);
    repeat (200) @(negedge mclk);
    check("bus idle", {scl_w, sda_w}, 32'h3);
    bus(1'b0, `SHR_OFF_CTRL, 32'h0);
    check("no status", rd[`SHR_CTL_SI], 32'h0);
    bus(1'b1, `SHR_OFF_MASK, 32'h0);
    @(negedge mclk);
    check("irq masked", irq, 32'h0);
    end_sim();
  end
endmodule
